// file: rtl/tcm_port_pkg.sv
/*
  Shared constants, encodings and carriers of the tightly coupled memory
  port. Assumes a single clock domain and a 32-bit word memory.
*/
`default_nettype none
package tcm_port_pkg;

  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int LANE_W = 4;
  localparam int SIZE_CFG_W = 4;
  localparam int FIFO_DEPTH = 4;

  // Size configuration codes
  localparam logic [3:0] SIZE_ABSENT = 4'h0;
  localparam logic [3:0] SIZE_MIN = 4'h3;
  localparam logic [3:0] SIZE_MAX = 4'hb;

  // Reset values
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [17:0] ADDR_RST = 18'h00000;
  localparam logic [31:0] DATA_RST = 32'h00000000;

  typedef enum logic [1:0] {
    ACC_BYTE = 2'b00,
    ACC_HALF = 2'b01,
    ACC_WORD = 2'b10
  } acc_size_e;

  typedef struct packed {
    logic [17:0] addr;
    logic write;
    acc_size_e size;
    logic [1:0] byte_off;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic [31:0] rdata;
    logic write;
    logic err;
  } mem_rsp_s;

  localparam int REQ_W = $bits(mem_req_s);

endpackage : tcm_port_pkg
`default_nettype wire

// file: rtl/tcm_lane_decode.sv
/*
  Byte-lane strobe decoder for one memory access.
  Assumes little-endian lane order and a legal size code.
*/
`timescale 1ns/10ps
`default_nettype none
module tcm_lane_decode
  import tcm_port_pkg::*;
(
  input wire logic write,
  input wire acc_size_e size,
  input wire logic [1:0] byte_off,
  output logic [3:0] lanes
);

  genvar g;
  generate
    for (g = 0; g < LANE_W; g = g + 1)
    begin : g_lane
      localparam logic [1:0] LANE = 2'(g);
      // Reads never raise a lane
      assign lanes[g] = write &&
        ((size == ACC_WORD) ||
         (size == ACC_HALF && byte_off[1] == LANE[1]) ||
         (size == ACC_BYTE && byte_off == LANE));
    end
  endgenerate

endmodule : tcm_lane_decode
`default_nettype wire

// file: rtl/tcm_req_fifo.sv
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes one clock, synchronous reset and a power-of-two depth.
*/
`timescale 1ns/10ps
`default_nettype none
module tcm_req_fifo
  import tcm_port_pkg::*;
#(
  parameter int WIDTH = REQ_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] count_ff;
  logic push;
  logic pop;

  assign in_ready = (count_ff != FULL_CNT);
  assign out_valid = (count_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (ce && push)
    begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end
    else if (ce)
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + PW'(1);
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + PW'(1);
      if (push && !pop)
        count_ff <= count_ff + CW'(1);
      else if (pop && !push)
        count_ff <= count_ff - CW'(1);
    end
  end

endmodule : tcm_req_fifo
`default_nettype wire

// file: rtl/tightly_coupled_mem_port.sv
/*
  Processor-side port to a tightly coupled instruction memory, plus the
  byte-lane and write-data outputs of the data-memory port. Assumes the
  memory, the DMA agent and the core all run on clk.
*/
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Data lanes are driven in request cycles, all zero on reads.
// - Data write data is valid in request cycles and held while waited.
// - The reset strap enables the memory and, without high vectors, boot.
// - An 18-bit word address is output, valid in request cycles.
// - Chip select rises in the cycle before the access it announces.
// - With DMA enabled the DMA address passes through, selects are ORed.
// - Idle is 0 during an access and 1 otherwise or when disabled.
// - The direction flag is 0 for reads and 1 for writes.
// - Sequential marks a follow-on address, and is high after each waited cycle.
// - Wait high in request or wait cycles stalls; otherwise ignored.
// - Instruction lanes are zero on reads and mark bytes on writes.
// - Instruction write data is valid in request and waited write cycles.
module tightly_coupled_mem_port
  import tcm_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic reset_imem_enable,
  input wire logic high_vectors_select,
  input wire logic [3:0] imem_size_cfg,
  output logic imem_enabled,
  output logic boot_from_imem,
  output logic size_cfg_reserved,
  input wire logic req_valid,
  output logic req_ready,
  input wire mem_req_s req,
  output logic rsp_valid,
  output mem_rsp_s rsp,
  output logic [17:0] imem_word_addr,
  output logic imem_chip_select,
  output logic imem_idle,
  output logic imem_dir_flag,
  output logic imem_sequential,
  output logic [3:0] imem_byte_lanes,
  output logic [31:0] imem_write_data,
  input wire logic [31:0] imem_read_data,
  input wire logic imem_wait,
  input wire logic imem_dma_enable,
  input wire logic [17:0] imem_dma_addr,
  input wire logic imem_dma_chip_select,
  input wire logic dmem_req_valid,
  output logic dmem_req_ready,
  input wire mem_req_s dmem_req,
  input wire logic dmem_wait,
  output logic [3:0] dmem_byte_lanes,
  output logic [31:0] dmem_write_data,
  output logic dmem_dir_flag
);

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_REQ = 1'b1
  } port_state_e;

  function automatic logic size_legal(input logic [3:0] code);
    size_legal = (code >= SIZE_MIN) && (code <= SIZE_MAX);
  endfunction : size_legal

  ////////////////////////////////////////////////////////////////////////
  // Reset strap and size configuration
  logic enabled_ff;
  logic hivec_ff;
  logic present;
  // Strap is caught on the clock while reset is held, not asynchronously
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enabled_ff <= reset_imem_enable;
      hivec_ff <= high_vectors_select;
    end
  end

  assign imem_enabled = enabled_ff;
  assign boot_from_imem = enabled_ff && !hivec_ff;
  // Reserved codes are flagged and treated as absent memory
  assign size_cfg_reserved = (imem_size_cfg != SIZE_ABSENT) &&
                             !size_legal(imem_size_cfg);
  assign present = enabled_ff && size_legal(imem_size_cfg);

  ////////////////////////////////////////////////////////////////////////
  // Request buffer
  logic q_valid;
  logic q_ready;
  mem_req_s q;
  logic [3:0] q_lanes;
  tcm_req_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q)
  );

  tcm_lane_decode u_imem_lanes (
    .write(q.write),
    .size(q.size),
    .byte_off(q.byte_off),
    .lanes(q_lanes)
  );

  ////////////////////////////////////////////////////////////////////////
  // Access sequencing
  port_state_e state_ff;
  logic done;
  logic slot;
  logic cs_int;
  logic drop;
  // Wait is only looked at in request and wait cycles
  assign done = (state_ff == ST_REQ) && !imem_wait;
  assign slot = (state_ff == ST_IDLE) || done;
  assign q_ready = slot;
  // Chip select may depend on wait, so back-to-back needs no gap
  assign cs_int = slot && q_valid && present;
  assign drop = slot && q_valid && !present;

  always_ff @(posedge clk)
  begin
    if (rst)
      state_ff <= ST_IDLE;
    else if (ce)
    begin
      unique case (state_ff)
        ST_IDLE:
          state_ff <= cs_int ? ST_REQ : ST_IDLE;
        ST_REQ:
          if (done)
            state_ff <= cs_int ? ST_REQ : ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Request outputs
  logic [17:0] addr_ff;
  logic dir_ff;
  logic [3:0] lanes_ff;
  logic [31:0] wdata_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      addr_ff <= ADDR_RST;
      dir_ff <= 1'b0;
      lanes_ff <= LANES_NONE;
      wdata_ff <= DATA_RST;
    end
    else if (ce)
    begin
      if (cs_int)
      begin
        addr_ff <= q.addr;
        dir_ff <= q.write;
        lanes_ff <= q_lanes;
        wdata_ff <= q.wdata;
      end
      else if (slot)
      begin
        // No strobe may stay up once the write is over
        lanes_ff <= LANES_NONE;
        dir_ff <= 1'b0;
      end
    end
  end

  // DMA override is combinational so the agent sees no added latency
  assign imem_word_addr = imem_dma_enable ? imem_dma_addr : addr_ff;
  assign imem_chip_select = cs_int ||
                            (imem_dma_enable && imem_dma_chip_select);
  assign imem_idle = (state_ff != ST_REQ);
  assign imem_dir_flag = dir_ff;
  assign imem_byte_lanes = lanes_ff;
  assign imem_write_data = wdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Sequential hint
  logic seq_ff;
  logic waited_ff;
  logic have_prev_ff;
  logic dma_seen_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      seq_ff <= 1'b0;
      have_prev_ff <= 1'b0;
    end
    else if (ce && cs_int)
    begin
      // Previous address is lost after DMA, so the hint is dropped
      seq_ff <= have_prev_ff && !dma_seen_ff &&
                (q.addr == addr_ff + 18'h00001);
      have_prev_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      waited_ff <= 1'b0;
    else if (ce)
      waited_ff <= (state_ff == ST_REQ) && imem_wait;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      dma_seen_ff <= 1'b0;
    else if (ce)
    begin
      // Set wins over clear when both land in one cycle
      if (imem_dma_enable && imem_dma_chip_select)
        dma_seen_ff <= 1'b1;
      else if (cs_int)
        dma_seen_ff <= 1'b0;
    end
  end

  assign imem_sequential = (state_ff == ST_REQ) && (seq_ff || waited_ff);

  ////////////////////////////////////////////////////////////////////////
  // Responses
  logic rsp_valid_ff;
  mem_rsp_s rsp_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_ff <= '0;
    end
    else if (ce)
    begin
      rsp_valid_ff <= done || drop;
      if (done)
      begin
        // Data is taken only when the cycle is not waited
        rsp_ff.rdata <= dir_ff ? DATA_RST : imem_read_data;
        rsp_ff.write <= dir_ff;
        rsp_ff.err <= 1'b0;
      end
      else if (drop)
      begin
        rsp_ff.rdata <= DATA_RST;
        rsp_ff.write <= q.write;
        rsp_ff.err <= 1'b1;
      end
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp = rsp_ff;

  ////////////////////////////////////////////////////////////////////////
  // Data-memory write lanes and data
  logic dmem_busy_ff;
  logic dmem_hold;
  logic [3:0] dmem_lanes_nxt;
  logic [3:0] dmem_lanes_ff;
  logic [31:0] dmem_wdata_ff;
  logic dmem_dir_ff;
  tcm_lane_decode u_dmem_lanes (
    .write(dmem_req.write),
    .size(dmem_req.size),
    .byte_off(dmem_req.byte_off),
    .lanes(dmem_lanes_nxt)
  );

  assign dmem_hold = dmem_busy_ff && dmem_wait;
  assign dmem_req_ready = !dmem_hold;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dmem_busy_ff <= 1'b0;
      dmem_lanes_ff <= LANES_NONE;
      dmem_wdata_ff <= DATA_RST;
      dmem_dir_ff <= 1'b0;
    end
    else if (ce && !dmem_hold)
    begin
      dmem_busy_ff <= dmem_req_valid;
      dmem_dir_ff <= dmem_req_valid && dmem_req.write;
      // Lanes fall to zero between accesses and on reads
      dmem_lanes_ff <= dmem_req_valid ? dmem_lanes_nxt
                                      : LANES_NONE;
      if (dmem_req_valid)
        dmem_wdata_ff <= dmem_req.wdata;
    end
  end

  assign dmem_byte_lanes = dmem_lanes_ff;
  assign dmem_write_data = dmem_wdata_ff;
  assign dmem_dir_flag = dmem_dir_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst || !ce);
  a_dmem_read_lanes: assert property (
    dmem_busy_ff && !dmem_dir_ff |-> dmem_byte_lanes == LANES_NONE)
    else $error("data lanes raised on a read");
  a_dmem_wdata_hold: assert property (
    dmem_busy_ff && dmem_wait && ce |=>
      $stable(dmem_write_data) && dmem_busy_ff)
    else $error("data write data moved while waited");
  a_boot_strap: assert property (
    $fell(rst) |-> imem_enabled == $past(reset_imem_enable) &&
      boot_from_imem == $past(reset_imem_enable && !high_vectors_select))
    else $error("boot strap not caught at reset");
  a_cs_leads_req: assert property (
    cs_int && ce |=> !imem_idle && imem_word_addr == $past(q.addr)
      || imem_dma_enable)
    else $error("access did not follow chip select");
  a_dma_pass: assert property (
    imem_dma_enable |-> imem_word_addr == imem_dma_addr &&
      (imem_dma_chip_select -> imem_chip_select))
    else $error("dma override not honoured");
  a_idle_absent: assert property (
    !present |-> ##1 (imem_idle || $past(state_ff == ST_REQ)))
    else $error("access while memory disabled");
  a_read_sample: assert property (
    rsp_valid && !rsp.err && !rsp.write |->
      $past(state_ff == ST_REQ && !imem_wait && !dir_ff))
    else $error("read data taken in a waited cycle");
  a_seq_on_wait: assert property (
    state_ff == ST_REQ && imem_wait && ce |=>
      imem_sequential && state_ff == ST_REQ)
    else $error("sequential low during wait");
  a_wait_stall: assert property (
    state_ff == ST_REQ && imem_wait && ce |=>
      $stable(imem_write_data) && $stable(addr_ff) &&
      $stable(imem_byte_lanes))
    else $error("request moved during wait");
  a_imem_read_lanes: assert property (
    !imem_dir_flag |-> imem_byte_lanes == LANES_NONE)
    else $error("instruction lanes raised without a write");
  c_waited_write: cover property (
    state_ff == ST_REQ && dir_ff && imem_wait ##1 done);
  c_back_to_back: cover property (done && cs_int ##1 done);
  c_dma_access: cover property (
    imem_dma_enable && imem_dma_chip_select ##[1:20] cs_int);

endmodule : tightly_coupled_mem_port
`default_nettype wire

// file: tb/tcm_sram_model.sv
/*
  Behavioural tightly coupled SRAM that faces the memory port.
  Assumes the shared clock and a wait budget set per access by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module tcm_sram_model
(
  input wire logic clk,
  input wire logic [17:0] addr,
  input wire logic idle,
  input wire logic dir,
  input wire logic [3:0] lanes,
  input wire logic [31:0] wdata,
  input wire logic [7:0] wait_n,
  output logic [31:0] rdata,
  output logic stall
);
  logic [31:0] mem [16];
  logic [31:0] last = '0;
  logic [7:0] wcnt = '0;
  ////////////////////////////////////////////////////////////////////////////
  // High outside accesses too, on purpose: the port has to ignore it there
  assign stall = wcnt < wait_n;
  // Changing junk outside unwaited cycles, so a stale sample cannot match
  assign rdata = (!idle && !stall) ? mem[addr[3:0]] : ~last;
  always @(posedge clk)
  begin
    last <= rdata;
    wcnt <= (!idle && stall) ? wcnt + 8'h01 : 8'h00;
    if (!idle && !stall && dir)
      for (int i = 0; i < 4; i++)
        if (lanes[i])
          mem[addr[3:0]][i*8 +: 8] <= wdata[i*8 +: 8];
  end
endmodule : tcm_sram_model
`default_nettype wire

// file: tb/test_tightly_coupled_mem_port.sv
/*
  Self-checking bench for the tightly coupled memory port.
  Assumes the SRAM model beside it and one 100 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module test_tightly_coupled_mem_port
  import tcm_port_pkg::*;
;
  logic clk, rst, req_valid, dmem_req_valid, dmem_wait, dma_en, dma_cs;
  logic en, boot, resv, req_ready, rsp_valid, idle, cs, dir, seq, stall;
  logic dm_ready, dm_dir, cap_dir, cap_seq;
  logic strap_en, strap_hi, cs_lead, cap_cs;
  logic [3:0] size_cfg, lanes, dm_lanes, cap_lanes;
  logic [17:0] dma_addr, addr, cap_addr;
  logic [31:0] wd, rd, dm_wd, cap_wd;
  logic [7:0] wait_n;
  mem_req_s req, dmem_req;
  mem_rsp_s rsp, got;
  int rc, cyc, fail_count, samples_checked;
  ////////////////////////////////////////////////////////////////////////////
  tightly_coupled_mem_port dut_u (.clk(clk), .rst(rst), .ce(1'b1),
    .reset_imem_enable(strap_en), .high_vectors_select(strap_hi),
    .imem_size_cfg(size_cfg), .imem_enabled(en), .boot_from_imem(boot),
    .size_cfg_reserved(resv), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .rsp_valid(rsp_valid), .rsp(rsp), .imem_word_addr(addr),
    .imem_chip_select(cs), .imem_idle(idle), .imem_dir_flag(dir),
    .imem_sequential(seq), .imem_byte_lanes(lanes), .imem_write_data(wd),
    .imem_read_data(rd), .imem_wait(stall), .imem_dma_enable(dma_en),
    .imem_dma_addr(dma_addr), .imem_dma_chip_select(dma_cs),
    .dmem_req_valid(dmem_req_valid), .dmem_req_ready(dm_ready),
    .dmem_req(dmem_req), .dmem_wait(dmem_wait), .dmem_byte_lanes(dm_lanes),
    .dmem_write_data(dm_wd), .dmem_dir_flag(dm_dir));
  tcm_sram_model mem_u (.clk(clk), .addr(addr), .idle(idle), .dir(dir),
    .lanes(lanes), .wdata(wd), .wait_n(wait_n), .rdata(rd), .stall(stall));
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Keeps what the port showed in the last unwaited access cycle
  always @(posedge clk)
  begin
    if (!idle)
      rc++;
    else
      cs_lead = cs;
    if (!idle && !stall)
    begin
      cap_cs = cs_lead;
      cap_addr = addr;
      cap_dir = dir;
      cap_lanes = lanes;
      cap_wd = wd;
      cap_seq = seq;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input acc_size_e s, input logic [1:0] o,
                     input logic [17:0] a, input logic [31:0] d);
    int rc0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{a, w, s, o, d};
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    rc0 = rc;
    do @(negedge clk); while (rsp_valid !== 1'b1);
    got = rsp;
    cyc = rc - rc0;
  endtask : acc
  task automatic t_reset;
    @(negedge clk);
    chk("idle", 1, idle);
    chk("lanes", 0, lanes);
    chk("enabled", 1, en);
    chk("boot", 1, boot);
    chk("dmem lanes", 0, dm_lanes);
    $display("test reset done");
  endtask : t_reset
  task automatic t_lanes;
    acc(1'b1, ACC_WORD, 2'h0, 18'h2, 32'h11223344);
    chk("lanes", 4'hf, cap_lanes);
    chk("dir", 1, cap_dir);
    chk("addr", 2, cap_addr);
    chk("wdata", 32'h11223344, cap_wd);
    chk("err", 0, got.err);
    chk("write", 1, got.write);
    chk("cs lead", 1, cap_cs);
    acc(1'b1, ACC_BYTE, 2'h1, 18'h2, 32'h0000ee00);
    chk("lanes", 4'h2, cap_lanes);
    acc(1'b0, ACC_WORD, 2'h0, 18'h2, 32'h0);
    chk("lanes", 0, cap_lanes);
    chk("dir", 0, cap_dir);
    chk("rdata", 32'h1122ee44, got.rdata);
    for (int i = 0; i < 6; i++)
    begin
      acc(1'b1, i < 4 ? ACC_BYTE : ACC_HALF, 2'(i < 4 ? i : 2*i-8), 18'h3, 0);
      chk("lanes", i < 4 ? 1 << i : 3 << (2*i-8), cap_lanes);
    end
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_wait;
    @(posedge clk);
    wait_n <= 8'h02;
    // Not a follow-on address, so only the wait can raise seq
    acc(1'b1, ACC_WORD, 2'h0, 18'h6, 32'hcafe0001);
    chk("cycles", 3, cyc);
    chk("wdata", 32'hcafe0001, cap_wd);
    chk("seq", 1, cap_seq);
    acc(1'b0, ACC_WORD, 2'h0, 18'h6, 32'h0);
    chk("rdata", 32'hcafe0001, got.rdata);
    @(posedge clk);
    wait_n <= 8'h00;
    $display("test wait done");
  endtask : t_wait
  task automatic t_seq;
    acc(1'b0, ACC_WORD, 2'h0, 18'h7, 32'h0);
    acc(1'b0, ACC_WORD, 2'h0, 18'h8, 32'h0);
    chk("seq", 1, cap_seq);
    acc(1'b0, ACC_WORD, 2'h0, 18'ha, 32'h0);
    chk("seq", 0, cap_seq);
    $display("test seq done");
  endtask : t_seq
  task automatic t_dma;
    @(posedge clk);
    dma_en <= 1'b1;
    dma_addr <= 18'h2aaaa;
    dma_cs <= 1'b1;
    @(negedge clk);
    chk("addr", 18'h2aaaa, addr);
    chk("cs", 1, cs);
    @(posedge clk);
    dma_addr <= 18'h15555;
    dma_cs <= 1'b0;
    @(negedge clk);
    chk("addr", 18'h15555, addr);
    chk("cs", 0, cs);
    @(posedge clk);
    dma_en <= 1'b0;
    // Follows on from the last address, but the hint is lost after DMA
    acc(1'b0, ACC_WORD, 2'h0, 18'hb, 32'h0);
    chk("seq", 0, cap_seq);
    $display("test dma done");
  endtask : t_dma
  task automatic t_fifo;
    int n;
    int k;
    n = 0;
    k = 0;
    @(posedge clk);
    wait_n <= 8'd20;
    req_valid <= 1'b1;
    req <= '{18'h20, 1'b0, ACC_WORD, 2'h0, 32'h0};
    // One access held in flight by the stall plus four queued
    repeat (10)
    begin
      @(negedge clk);
      if (req_ready !== 1'b1)
        break;
      @(posedge clk);
      n++;
      req.addr <= 18'(32'h20 + n);
    end
    @(posedge clk);
    req_valid <= 1'b0;
    wait_n <= 8'h00;
    chk("pushed", 5, n);
    repeat (60)
    begin
      @(negedge clk);
      if (rsp_valid === 1'b1)
        k++;
    end
    chk("responses", 5, k);
    $display("test fifo done");
  endtask : t_fifo
  task automatic t_dmem;
    @(posedge clk);
    dmem_req_valid <= 1'b1;
    dmem_req <= '{18'h1, 1'b1, ACC_HALF, 2'h2, 32'hbeef0000};
    @(posedge clk);
    dmem_req_valid <= 1'b0;
    dmem_wait <= 1'b1;
    @(negedge clk);
    chk("dmem lanes", 4'hc, dm_lanes);
    chk("dmem dir", 1, dm_dir);
    chk("dmem wdata", 32'hbeef0000, dm_wd);
    chk("dmem ready", 0, dm_ready);
    @(posedge clk);
    dmem_wait <= 1'b0;
    @(negedge clk);
    chk("dmem wdata", 32'hbeef0000, dm_wd);
    chk("dmem lanes", 4'hc, dm_lanes);
    @(negedge clk);
    chk("dmem lanes", 0, dm_lanes);
    $display("test dmem done");
  endtask : t_dmem
  task automatic t_size;
    logic [3:0] codes [5] = '{4'h1, 4'h2, 4'hc, 4'hf, 4'h0};
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      size_cfg <= i < 5 ? codes[i] : 4'h3;
      @(negedge clk);
      chk("reserved", i < 4, resv);
      acc(1'b0, ACC_WORD, 2'h0, 18'h1, 32'h0);
      chk("err", i < 5, got.err);
    end
    $display("test size done");
  endtask : t_size
  task automatic t_strap;
    // Two more resets in mid-run: strap low, then strap high with high vectors
    @(posedge clk);
    rst <= 1'b1;
    strap_en <= 1'b0;
    strap_hi <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("enabled", 0, en);
    chk("boot", 0, boot);
    acc(1'b0, ACC_WORD, 2'h0, 18'h1, 32'h0);
    chk("err", 1, got.err);
    @(posedge clk);
    rst <= 1'b1;
    strap_en <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("enabled", 1, en);
    chk("boot", 0, boot);
    acc(1'b0, ACC_WORD, 2'h0, 18'h1, 32'h0);
    chk("err", 0, got.err);
    $display("test strap done");
  endtask : t_strap
  task automatic results;
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count++;
    results();
  end
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    dmem_req_valid = 1'b0;
    dmem_req = '0;
    dmem_wait = 1'b0;
    dma_en = 1'b0;
    dma_cs = 1'b0;
    dma_addr = '0;
    size_cfg = 4'hb;
    wait_n = 8'h00;
    strap_en = 1'b1;
    strap_hi = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_lanes();
    t_wait();
    t_seq();
    t_dma();
    t_fifo();
    t_dmem();
    t_size();
    t_strap();
    results();
  end
endmodule : test_tightly_coupled_mem_port
`default_nettype wire
